// ===== hdl/ubg_pkg.sv
package ubg_pkg;

  // Register bus geometry
  localparam int          ADR_W    = 8;
  localparam int          DIV_W    = 12;

  // Register byte offsets
  localparam logic [7:0]  ADR_DATA = 8'h00;
  localparam logic [7:0]  ADR_CSA  = 8'h04;
  localparam logic [7:0]  ADR_CSC  = 8'h08;
  localparam logic [7:0]  ADR_CEN  = 8'h0c;
  localparam logic [7:0]  ADR_BDL  = 8'h10;
  localparam logic [7:0]  ADR_BDH  = 8'h14;

  // ctrl_status_a fields
  localparam int CSA_DSPD = 0;
  localparam int CSA_RXC  = 1;
  localparam int CSA_TXC  = 2;
  localparam int CSA_UDRE = 3;
  localparam int CSA_FE   = 4;
  localparam int CSA_DOR  = 5;
  localparam int CSA_PE   = 6;

  // ctrl_status_c fields
  localparam int CSC_SYNC  = 0;
  localparam int CSC_XDIR  = 1;
  localparam int CSC_POL   = 2;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_PODD  = 4;
  localparam int CSC_PEN   = 5;
  localparam int CSC_SIZE  = 6;

  // ctrl_enable fields
  localparam int CEN_TXEN  = 0;
  localparam int CEN_RXEN  = 1;
  localparam int CEN_TXCIE = 2;
  localparam int CEN_UDRIE = 3;
  localparam int CEN_RXCIE = 4;
  localparam int CEN_PCUT  = 5;

  // Reset values
  localparam logic [8:0]  CSC_RST  = 9'h0c0;
  localparam logic [5:0]  CEN_RST  = 6'h20;

  // Sample counter tops and mid points per bit
  localparam logic [3:0]  TOP_NORM = 4'hf;
  localparam logic [3:0]  TOP_DBL  = 4'h7;
  localparam logic [3:0]  MID_NORM = 4'h8;
  localparam logic [3:0]  MID_DBL  = 4'h4;

  // Transmit and receive states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ubg_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ubg_rx_st_t;

  // One receive buffer entry
  typedef struct packed {
    logic       fe;
    logic       pe;
    logic [8:0] data;
  } ubg_rx_ent_t;

endpackage

// ===== hdl/ubg_baud_gen.sv
`timescale 1ns/100ps
module ubg_baud_gen #(
  parameter int DIV_W = ubg_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Divisor and reload strobe
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             load_i,
  // One cycle wide tick, held high while the divisor is zero
  output logic                  tick_o
);
  import ubg_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } ubg_bg_st_t;

  ubg_bg_st_t q;
  ubg_bg_st_t next_q;

  // Down-counter reloads at zero or on a low byte write
  always_comb begin
    next_q = q;
    if (load_i || q.cnt == '0) begin
      next_q.cnt = div_i;
    end else begin
      next_q.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Enable pulse, not a clock
  assign tick_o = (q.cnt == '0);
endmodule

// ===== hdl/ubg_pin_sync.sv
`timescale 1ns/100ps
module ubg_pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw pins
  input  wire logic [W-1:0] pins_i,
  // Synchronised level and edges
  output logic [W-1:0]      lvl_o,
  output logic [W-1:0]      rise_o,
  output logic [W-1:0]      fall_o
);
  import ubg_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ubg_ps_st_t;

  ubg_ps_st_t q;
  ubg_ps_st_t next_q;

  // Two flops, then a delay flop for the edge detector
  always_comb begin
    next_q    = q;
    next_q.s1 = pins_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '1;
    end else begin
      q <= next_q;
    end
  end

  assign lvl_o  = q.s2;
  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;
endmodule

// ===== hdl/ubg_usart.sv
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/100ps
module ubg_usart (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Classic Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ubg_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // Serial data line
  input  wire logic                      rxd_i,
  output logic                           txd_o,
  // Transfer clock pin
  input  wire logic                      xck_i,
  output logic                           xck_o,
  output logic                           xck_oe_o,
  // Interrupt requests
  output logic                           txc_irq_o,
  output logic                           udre_irq_o,
  output logic                           rxc_irq_o
);
  import ubg_pkg::*;

  typedef struct packed {
    logic                   ack;
    logic [31:0]            dat;
    logic                   dbl;
    logic [8:0]             csc;
    logic [5:0]             cen;
    logic [DIV_W-1:0]       div;
    logic                   div_ld;
    logic                   xck;
    ubg_tx_st_t             txs;
    logic [8:0]             tbuf;
    logic                   tfull;
    logic [8:0]             tsr;
    logic [3:0]             tcnt;
    logic [3:0]             tpre;
    logic                   tpar;
    logic                   txd;
    logic                   txc;
    ubg_rx_st_t             rxs;
    logic [8:0]             rsr;
    logic [3:0]             rcnt;
    logic [3:0]             rbit;
    logic                   rpar;
    ubg_rx_ent_t [1:0]      rbuf;
    logic [1:0]             rlvl;
    logic                   dor;
  } ubg_st_t;

  ubg_st_t     q;
  ubg_st_t     next_q;
  logic        bg_tick;
  logic        tick;
  logic [1:0]  ps_lvl;
  logic [1:0]  ps_rise;
  logic [1:0]  ps_fall;
  logic        sync;
  logic        master;
  logic        en;
  logic [3:0]  top;
  logic [3:0]  mid;
  logic [3:0]  nb_m1;
  logic        rise;
  logic        fall;
  logic        chg;
  logic        smp;
  logic        tbit;
  logic        rs;
  logic        rxd;
  logic        req;
  logic        acc;
  logic        wr;
  logic        ld_next;
  ubg_rx_ent_t ent;

  // Baud rate generator on the system clock
  ubg_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_i  (q.div),
    .load_i (q.div_ld),
    .tick_o (bg_tick)
  );

  // Pin synchronisers for clock pin and data line
  ubg_pin_sync #(
    .W (2)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({xck_i, rxd_i}),
    .lvl_o  (ps_lvl),
    .rise_o (ps_rise),
    .fall_o (ps_fall)
  );

  // Mode decode
  assign en     = ~q.cen[CEN_PCUT];
  assign tick   = bg_tick & en;
  assign sync   = q.csc[CSC_SYNC];
  assign master = q.csc[CSC_XDIR];
  assign top    = (q.dbl && !sync) ? TOP_DBL : TOP_NORM;
  assign mid    = (q.dbl && !sync) ? MID_DBL : MID_NORM;
  assign nb_m1  = (q.csc[8:6] > 3'h4) ? 4'h8 : {1'b0, q.csc[8:6]} + 4'h4;
  assign rxd    = ps_lvl[0];

  // Clock edges: own divided clock as master, synced pin as slave
  assign rise = master ? (tick & ~q.xck) : ps_rise[1];
  assign fall = master ? (tick & q.xck) : ps_fall[1];
  assign chg  = q.csc[CSC_POL] ? fall : rise;
  assign smp  = q.csc[CSC_POL] ? rise : fall;

  // Transmit bit enable and receive sample strobe
  assign tbit = sync ? chg : (tick && q.tpre == top);
  assign rs   = sync ? smp : (tick && q.rxs != RX_IDLE && q.rcnt == mid);

  // Bus handshake
  assign req     = wb_cyc_i & wb_stb_i;
  assign acc     = req & q.ack;
  assign wr      = acc & wb_we_i & wb_sel_i[0];
  assign ld_next = wr && wb_adr_i == ADR_BDL;

  // Received entry assembled at the stop bit
  assign ent.fe   = ~rxd;
  assign ent.pe   = q.csc[CSC_PEN] & q.rpar;
  assign ent.data = q.rsr >> (4'h8 - nb_m1);

  // Next state
  always_comb begin
    next_q        = q;
    next_q.ack    = req & ~q.ack;
    next_q.div_ld = ld_next;
    // Read data captured in the cycle before ack
    if (req && !q.ack) begin
      case (wb_adr_i)
        ADR_DATA: next_q.dat = {23'h0, q.rbuf[0].data};
        ADR_CSA:  next_q.dat = {25'h0, q.rbuf[0].pe, q.dor, q.rbuf[0].fe, ~q.tfull,
                                q.txc, q.rlvl != 2'h0, q.dbl};
        ADR_CSC:  next_q.dat = {23'h0, q.csc};
        ADR_CEN:  next_q.dat = {26'h0, q.cen};
        ADR_BDL:  next_q.dat = {24'h0, q.div[7:0]};
        ADR_BDH:  next_q.dat = {28'h0, q.div[11:8]};
        default:  next_q.dat = 32'h0;
      endcase
    end
    // Register writes at the ack edge
    if (wr) begin
      case (wb_adr_i)
        ADR_DATA: begin
          if (!q.tfull) begin
            next_q.tbuf  = {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
            next_q.tfull = 1'b1;
          end
        end
        ADR_CSA: begin
          next_q.dbl = wb_dat_i[CSA_DSPD];
          if (wb_dat_i[CSA_TXC]) begin
            next_q.txc = 1'b0;
          end
        end
        ADR_CSC:  next_q.csc = {wb_sel_i[1] ? wb_dat_i[8] : q.csc[8], wb_dat_i[7:0]};
        ADR_CEN:  next_q.cen = wb_dat_i[5:0];
        ADR_BDL:  next_q.div[7:0] = wb_dat_i[7:0];
        ADR_BDH:  next_q.div[11:8] = wb_dat_i[3:0];
        default: ;
      endcase
    end
    // Master clock toggles per tick, drops with the enable so no high undriven pin
    if (next_q.csc[CSC_SYNC] && next_q.csc[CSC_XDIR] && !next_q.cen[CEN_PCUT]) begin
      if (tick) begin
        next_q.xck = ~q.xck;
      end
    end else begin
      next_q.xck = 1'b0;
    end
    // Transmit prescaler in async modes
    if (tick) begin
      next_q.tpre = (q.tpre == top) ? 4'h0 : q.tpre + 4'h1;
    end
    // Transmitter
    if (!q.cen[CEN_TXEN] || !en) begin
      next_q.txs = TX_IDLE;
      next_q.txd = 1'b1;
    end else if (tbit) begin
      case (q.txs)
        TX_START: begin
          next_q.txd  = q.tsr[0];
          next_q.tpar = q.tpar ^ q.tsr[0];
          next_q.tsr  = {1'b0, q.tsr[8:1]};
          next_q.tcnt = 4'h0;
          next_q.txs  = TX_DATA;
        end
        TX_DATA: begin
          if (q.tcnt == nb_m1) begin
            next_q.txd  = q.csc[CSC_PEN] ? q.tpar : 1'b1;
            next_q.txs  = q.csc[CSC_PEN] ? TX_PAR : TX_STOP;
            next_q.tcnt = 4'h0;
          end else begin
            next_q.txd  = q.tsr[0];
            next_q.tpar = q.tpar ^ q.tsr[0];
            next_q.tsr  = {1'b0, q.tsr[8:1]};
            next_q.tcnt = q.tcnt + 4'h1;
          end
        end
        TX_PAR: begin
          next_q.txd  = 1'b1;
          next_q.tcnt = 4'h0;
          next_q.txs  = TX_STOP;
        end
        default: begin
          // Idle, or end of a stop bit (the first of two when CSC_STOP2 is set)
          if (q.txs == TX_STOP && q.csc[CSC_STOP2] && q.tcnt == 4'h0) begin
            next_q.tcnt = 4'h1;
          end else if (next_q.tfull) begin
            next_q.tsr   = next_q.tbuf;
            next_q.tfull = 1'b0;
            next_q.tpar  = q.csc[CSC_PODD];
            next_q.txd   = 1'b0;
            next_q.txs   = TX_START;
          end else begin
            next_q.txd = 1'b1;
            next_q.txs = TX_IDLE;
            if (q.txs == TX_STOP) begin
              next_q.txc = 1'b1;
            end
          end
        end
      endcase
    end
    // Receive sample counter, one step per tick
    if (!sync && tick && q.rxs != RX_IDLE) begin
      next_q.rcnt = (q.rcnt == top) ? 4'h0 : q.rcnt + 4'h1;
    end
    // Pop on data register read
    if (acc && !wb_we_i && wb_adr_i == ADR_DATA && q.rlvl != 2'h0) begin
      next_q.rbuf[0] = q.rbuf[1];
      next_q.rlvl    = q.rlvl - 2'h1;
      next_q.dor     = 1'b0;
    end
    // Receiver
    if (!q.cen[CEN_RXEN] || !en) begin
      next_q.rxs = RX_IDLE;
    end else begin
      case (q.rxs)
        RX_IDLE: begin
          if (sync ? (smp && !rxd) : (tick && !rxd)) begin
            next_q.rxs  = sync ? RX_DATA : RX_START;
            next_q.rcnt = 4'h1;
            next_q.rbit = 4'h0;
            next_q.rpar = q.csc[CSC_PODD];
          end
        end
        RX_START: begin
          if (rs) begin
            next_q.rxs = rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rs) begin
            next_q.rsr  = {rxd, q.rsr[8:1]};
            next_q.rpar = q.rpar ^ rxd;
            next_q.rbit = q.rbit + 4'h1;
            if (q.rbit == nb_m1) begin
              next_q.rxs = q.csc[CSC_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rs) begin
            next_q.rpar = q.rpar ^ rxd;
            next_q.rxs  = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rs) begin
            next_q.rxs = RX_IDLE;
            if (next_q.rlvl == 2'h2) begin
              next_q.dor = 1'b1;
            end else begin
              next_q.rbuf[next_q.rlvl[0]] = ent;
              next_q.rlvl = next_q.rlvl + 2'h1;
            end
          end
        end
        default: next_q.rxs = RX_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q     <= '0;
      q.csc <= CSC_RST;
      q.cen <= CEN_RST;
      q.txd <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  assign wb_dat_o   = q.dat;
  assign wb_ack_o   = q.ack;
  assign txd_o      = q.txd;
  assign xck_o      = q.xck;
  assign xck_oe_o   = sync & master & en;
  assign txc_irq_o  = q.txc & q.cen[CEN_TXCIE];
  assign udre_irq_o = ~q.tfull & q.cen[CEN_UDRIE];
  assign rxc_irq_o  = (q.rlvl != 2'h0) & q.cen[CEN_RXCIE];
endmodule

// ===== dv/ubg_serial_peer.sv
`timescale 1ns/100ps
module ubg_serial_peer (
  // Clock
  input  wire logic clk_i,
  // Line from the block
  input  wire logic txd_i,
  // Lines to the block
  output logic      rxd_o,
  output logic      xck_o
);
  // Idle line high, clock still
  initial begin
    rxd_o = 1'b1;
    xck_o = 1'b0;
  end

  // Send n frame bits, p cycles each, s runs a slave clock
  task automatic send(input logic [11:0] f, input int n, input int p, input bit s);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      xck_o <= s;
      repeat (p / 2) @(posedge clk_i);
      xck_o <= 1'b0;
      repeat (p - p / 2 - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  // Capture n bits from the first start edge, no resync
  task automatic grab(output logic [31:0] q, input int n, input int p);
    int k;
    q = 'x;
    for (k = 0; k < 4000 && txd_i !== 1'b0; k++) @(negedge clk_i);
    repeat (p / 2) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      q[i] = txd_i;
      repeat (p) @(negedge clk_i);
    end
  endtask
endmodule

// ===== dv/ubg_usart_properties.sv
`timescale 1ns/100ps
module ubg_usart_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic wb_ack_o,
  input wire logic txd_o,
  input wire logic xck_o,
  input wire logic xck_oe_o,
  input wire logic txc_irq_o,
  input wire logic udre_irq_o,
  input wire logic rxc_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Clock pin only moves while driven
  a_pin_undriven: assert property (!xck_oe_o |-> !xck_o)
    else $error("clock pin high while undriven");
  a_pin_moves: assert property ($changed(xck_o) |-> xck_oe_o || $past(xck_oe_o))
    else $error("clock pin moved while undriven");
  // Quiet outputs after reset
  a_reset_quiet: assert property ($fell(rst_i) |-> txd_o && !xck_oe_o && !wb_ack_o)
    else $error("outputs not idle after reset");
  a_irq_reset: assert property ($fell(rst_i) |-> !(txc_irq_o || udre_irq_o || rxc_irq_o))
    else $error("request high after reset");
  // Flags drop only through an access
  a_rx_pop_bus: assert property ($fell(rxc_irq_o) |-> $past(wb_ack_o) || $past(rst_i))
    else $error("receive request fell without access");
  a_txc_clear_bus: assert property ($fell(txc_irq_o) |-> $past(wb_ack_o) || $past(rst_i))
    else $error("complete request fell without access");
  a_udre_fill_bus: assert property ($fell(udre_irq_o) |-> $past(wb_ack_o) || $past(rst_i))
    else $error("empty request fell without access");
  // Shortest bit is two cycles
  a_txd_bit_hold: assert property ($changed(txd_o) |=> $stable(txd_o))
    else $error("serial bit shorter than two cycles");

  c_rx_done: cover property ($rose(rxc_irq_o));
  c_master: cover property ($rose(xck_oe_o));
  c_tx_start: cover property ($fell(txd_o));
endmodule

bind ubg_usart ubg_usart_properties ubg_usart_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o), .txd_o(txd_o),
  .xck_o(xck_o), .xck_oe_o(xck_oe_o), .txc_irq_o(txc_irq_o),
  .udre_irq_o(udre_irq_o), .rxc_irq_o(rxc_irq_o));

// ===== dv/ubg_usart_tb.sv
`timescale 1ns/100ps
module ubg_usart_tb;
  import ubg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat, dout, g, e;
  logic        ack, txd, rxd, xcko, xoe, pxck, tirq, uirq, rirq;
  logic [11:0] fr[3];
  logic [8:0]  dat[3];
  int          mismatches = 0;
  int          checks_done = 0;
  int          k, d, p, n;
  logic [31:0] seed = 32'h147b4f48;
  // Mode table: double speed, frame format, width, parity, odd, ticks per bit
  int          dsp[3] = '{0, 1, 0};
  int          csc[3] = '{'h0c0, 'h0e0, 'h130};
  int          dw[3]  = '{8, 8, 9};
  int          pe[3]  = '{0, 1, 1};
  int          od[3]  = '{0, 0, 1};
  int          mul[3] = '{16, 8, 16};
  logic [7:0]  ra[4]  = '{ADR_CSA, ADR_CSC, ADR_CEN, 8'h18};
  logic [31:0] rv[4]  = '{32'h8, 32'hc0, 32'h20, 32'h0};

  ubg_usart ubg_usart_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .rxd_i(rxd), .txd_o(txd), .xck_i(xoe ? xcko : pxck), .xck_o(xcko),
    .xck_oe_o(xoe), .txc_irq_o(tirq), .udre_irq_o(uirq), .rxc_irq_o(rirq));
  ubg_serial_peer ubg_serial_peer_i (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd), .xck_o(pxck));

  // 100 MHz clock
  initial forever #5 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Frame bits, first on the line in bit 0
  function automatic logic [11:0] frm(input logic [8:0] v, input int w, input int pb, input int o);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < w; i++) f[i+1] = v[i];
    if (pb != 0) f[w+1] = ^v ^ o[0];
    return f;
  endfunction

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= v;
    for (t = 0; t < 50; t++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rdat = dout;
    cyc  <= 1'b0;
    if (t == 50) begin
      mismatches++;
      conclude();
    end
    @(posedge clk_i);
  endtask

  // Bounded wait for a level on the master clock pin
  task automatic wait_xck(input logic v);
    for (k = 0; k < 2000 && xcko !== v; k++) @(posedge clk_i);
    if (k == 2000) begin
      mismatches++;
      conclude();
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped place
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      cmp(rdat, rv[i]);
    end
    bus(1'b1, ADR_CEN, 32'h1f);
    cmp(uirq, 1'b1);
    // Asynchronous modes, full duplex
    for (int m = 0; m < 3; m++) begin
      d = rnd() % 3;
      p = mul[m] * (d + 1);
      n = 2 + dw[m] + pe[m];
      bus(1'b1, ADR_BDH, 32'h0);
      bus(1'b1, ADR_BDL, d);
      bus(1'b1, ADR_CSC, csc[m]);
      bus(1'b1, ADR_CSA, dsp[m] | 4);
      cmp(xoe, 1'b0);
      for (int f = 0; f < 3; f++) begin
        dat[f] = rnd() & ((1 << dw[m]) - 1);
        fr[f] = frm(dat[f], dw[m], pe[m], od[m]);
      end
      e = (32'(frm(dat[1], dw[m], pe[m], od[m])) << n) | (32'(fr[0]) & ((32'h1 << n) - 1));
      e = e & ((32'h1 << (2 * n)) - 1);
      fr[1][n-1] = 1'b0;
      fork
        begin
          bus(1'b1, ADR_DATA, dat[0]);
          // Second word only once the buffer is free again
          for (k = 0; k < 2000 && uirq !== 1'b1; k++) @(posedge clk_i);
          if (k == 2000) begin
            mismatches++;
            conclude();
          end
          bus(1'b1, ADR_DATA, dat[1]);
        end
        ubg_serial_peer_i.grab(g, 2 * n, p);
        for (int f = 0; f < 3; f++) begin
          ubg_serial_peer_i.send(fr[f], n, p, 1'b0);
          repeat (p) @(posedge clk_i);
        end
      join
      cmp(g & ((32'h1 << (2 * n)) - 1), e);
      cmp(rirq, 1'b1);
      bus(1'b0, ADR_CSA, 32'h0);
      cmp(rdat & 32'h73, dsp[m] | 32'h22);
      bus(1'b0, ADR_DATA, 32'h0);
      cmp(rdat & 32'h1ff, dat[0]);
      bus(1'b0, ADR_CSA, 32'h0);
      cmp(rdat & 32'h73, dsp[m] | 32'h12);
      bus(1'b0, ADR_DATA, 32'h0);
      cmp(rdat & 32'h1ff, dat[1]);
      cmp(rirq, 1'b0);
      repeat (p) @(posedge clk_i);
      cmp(tirq, 1'b1);
      bus(1'b1, ADR_CSA, dsp[m] | 4);
      cmp(tirq, 1'b0);
    end
    // Synchronous master, divisor with high byte, double speed kept clear
    bus(1'b1, ADR_BDH, 32'h1);
    bus(1'b1, ADR_BDL, 32'h0);
    bus(1'b1, ADR_CSC, 32'h0c3);
    bus(1'b1, ADR_CSA, 32'h0);
    cmp(xoe, 1'b1);
    wait_xck(1'b0);
    wait_xck(1'b1);
    wait_xck(1'b0);
    cmp(32'(k), 32'd257);
    // Synchronous slave, clock from the peer
    bus(1'b1, ADR_CSA, 32'h0);
    bus(1'b1, ADR_CSC, 32'h0c1);
    cmp(xoe, 1'b0);
    dat[0] = rnd() & 32'hff;
    ubg_serial_peer_i.send(frm(dat[0], 8, 0, 0), 10, 8, 1'b1);
    repeat (8) @(posedge clk_i);
    bus(1'b0, ADR_DATA, 32'h0);
    cmp(rdat & 32'h1ff, dat[0]);
    conclude();
  end
endmodule
